// ---- rtl/acc_pkg.sv ----
package acc_pkg;
    // register index = printed offset, byte address = index * 4
    localparam logic [2:0] IDX_MAIN_CTRL = 3'h0;
    localparam logic [2:0] IDX_INPUT_SEL = 3'h2;
    localparam logic [2:0] IDX_REF_LEVEL = 3'h4;
    localparam logic [2:0] IDX_IRQ_CTRL = 3'h6;
    localparam logic [2:0] IDX_STATUS = 3'h7;
    localparam int ADDR_LSB = 2;
    // reset values
    localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
    localparam logic [7:0] RST_INPUT_SEL = 8'h00;
    localparam logic [7:0] RST_REF_LEVEL = 8'hff;
    localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
    // main control fields
    localparam int B_ENABLE = 0;
    localparam int B_HYS_LO = 1;
    localparam int B_LOW_POWER = 3;
    localparam int B_EDGE_LO = 4;
    localparam int B_PAD_EN = 6;
    localparam int B_STANDBY_RUN = 7;
    // input select fields
    localparam int B_MINUS_LO = 0;
    localparam int B_PLUS_LO = 3;
    localparam int B_INVERT = 7;
    // irq control and status fields
    localparam int B_IRQ_EN = 0;
    localparam int B_FLAG = 0;
    localparam int B_STATE = 4;
    // edge select codes; code 2'h1 is reserved
    localparam logic [1:0] EDGE_ANY = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_RISE = 2'h3;
    localparam logic [1:0] MINUS_REF_DIV = 2'h3;
    // start-up time, longest wait for a valid output
    localparam int STARTUP_NS = 2500;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STARTUP_CYC =
        (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
endpackage : acc_pkg

// ---- rtl/acc_det_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries the synchronised level and the edge hit between the blocks
interface acc_det_if;
    logic ce;
    logic level;
    logic valid;
    logic [1:0] edge_sel;
    logic hit;
    modport syn (input ce, output level);
    modport det (input ce, input level, input valid, input edge_sel,
                 output hit);
    modport ctl (output ce, output valid, output edge_sel,
                 input level, input hit);
endinterface : acc_det_if
`default_nettype wire

// ---- rtl/acc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for the asynchronous comparator level
module acc_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_in,
    acc_det_if.syn dif
);
    logic meta_ff;
    logic sync_ff;

    // only sync_ff reads meta_ff
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else if (dif.ce) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign dif.level = sync_ff;
endmodule : acc_sync
`default_nettype wire

// ---- rtl/acc_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
// edge detector on the synchronised, inverted comparator level
module acc_edge
    import acc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    acc_det_if.det dif
);
    logic prev_ff;
    logic rise;
    logic fall;

    // prev follows the level even while invalid, so no false edge appears
    // at the moment the start-up wait ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ff <= 1'b0;
        end else if (dif.ce) begin
            prev_ff <= dif.level;
        end
    end

    assign rise = dif.level & ~prev_ff;
    assign fall = ~dif.level & prev_ff;

    // edge select picks the transitions; reserved code gives nothing
    always_comb begin
        case (dif.edge_sel)
            EDGE_ANY: dif.hit = dif.valid & (rise | fall);
            EDGE_FALL: dif.hit = dif.valid & fall;
            EDGE_RISE: dif.hit = dif.valid & rise;
            default: dif.hit = 1'b0;
        endcase
    end
endmodule : acc_edge
`default_nettype wire

// ---- rtl/acc_top.sv ----
// Function
// - control bit 0 switches comparator on/off
// - output invalid during start-up wait after enable
// - control bits 2:1 select hysteresis level
// - control bit 3 selects low-power mode
// - control bits 5:4 select interrupt edges
// - selected output edge sets the status flag
// - irq while flag and enable both set
// - control bit 6 drives output to pad
// - input select bit 7 inverts output everywhere
// - input select bits 4:3 pick plus pin
// - bits 1:0 pick minus pin or divider
// - result continuously available to software, event, pin
// - export output as asynchronous level event
// - no incoming events are accepted
// - idle sleep keeps everything running normally
// - standby halts unless standby run bit set
// - stopped clock in standby freezes status bits
// - power-down disables comparator and pad output
// - output high when plus exceeds minus
// - status bit 4 shows output, three-cycle lag
// - writing one to flag clears it
// - reference level resets 0xff, sets divider
`timescale 1ns/1ps
`default_nettype none
module acc_top
    import acc_pkg::*;
#(
    parameter int REF_EXTRA_CYC = 100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // sleep state from the power manager, same clock domain
    input wire logic sleep_idle,
    input wire logic sleep_standby,
    input wire logic sleep_powerdown,
    // analog comparator core
    input wire logic cmp_raw,
    output logic cmp_enable,
    output logic [1:0] hysteresis_select,
    output logic low_power_select,
    output logic [1:0] plus_input_select,
    output logic [1:0] minus_input_select,
    output logic [7:0] ref_divider_level,
    // pad, event and interrupt
    output logic pad_out,
    output logic pad_oe,
    output logic event_out,
    output logic irq
);
    // registers
    logic [7:0] main_control_ff;
    logic [7:0] input_select_control_ff;
    logic [7:0] ref_divider_level_ff;
    logic irq_enable_ff;
    logic flag_ff;
    logic nxt_flag;
    logic state_ff;
    // comparator power and start-up
    logic core_on;
    logic cmp_on_ff;
    logic valid_ff;
    logic [CNT_W-1:0] wait_cnt_ff;
    logic [CNT_W-1:0] wait_limit;
    logic out_level_ff;
    logic pad_oe_ff;
    logic irq_ff;
    logic inv_level;
    // bus
    logic addr_ok;
    logic wr_pend_ff;
    logic [2:0] wr_idx_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_word;
    logic [2:0] rd_idx;
    logic wr_status;

    acc_det_if dif ();

    // word index from byte address; mapped only where a register sits
    function automatic logic acc_mapped(input logic [2:0] idx);
        acc_mapped = (idx == IDX_MAIN_CTRL) || (idx == IDX_INPUT_SEL) ||
                     (idx == IDX_REF_LEVEL) || (idx == IDX_IRQ_CTRL) ||
                     (idx == IDX_STATUS);
    endfunction : acc_mapped

    // --- address phase capture -----------------------------------------
    assign addr_ok = hsel & htrans[1] & hready;
    assign rd_idx = haddr[ADDR_LSB+2:ADDR_LSB];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 3'h0;
        end else if (hclk_en) begin
            wr_pend_ff <= addr_ok & hwrite & acc_mapped(rd_idx);
            wr_idx_ff <= rd_idx;
        end
    end

    // read mux; reserved bits and unmapped words read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_idx)
            IDX_MAIN_CTRL: rd_word[7:0] = main_control_ff;
            IDX_INPUT_SEL: begin
                rd_word[B_INVERT] = input_select_control_ff[B_INVERT];
                rd_word[B_PLUS_LO+1:B_PLUS_LO] =
                    input_select_control_ff[B_PLUS_LO+1:B_PLUS_LO];
                rd_word[B_MINUS_LO+1:B_MINUS_LO] =
                    input_select_control_ff[B_MINUS_LO+1:B_MINUS_LO];
            end
            IDX_REF_LEVEL: rd_word[7:0] = ref_divider_level_ff;
            IDX_IRQ_CTRL: rd_word[B_IRQ_EN] = irq_enable_ff;
            IDX_STATUS: begin
                rd_word[B_STATE] = state_ff;
                rd_word[B_FLAG] = flag_ff;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read data is sampled in the address phase, stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (hclk_en) begin
            if (addr_ok && !hwrite && acc_mapped(rd_idx)) begin
                hrdata_ff <= rd_word;
            end else begin
                hrdata_ff <= 32'h0000_0000;
            end
        end
    end

    // --- register writes in the data phase --------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_control_ff <= RST_MAIN_CTRL;
        end else if (hclk_en && wr_pend_ff && wr_idx_ff == IDX_MAIN_CTRL) begin
            main_control_ff <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_select_control_ff <= RST_INPUT_SEL;
        end else if (hclk_en && wr_pend_ff && wr_idx_ff == IDX_INPUT_SEL) begin
            // bits 6:5 and 2 are reserved and stay zero
            input_select_control_ff <= hwdata[7:0] & 8'h9b;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_divider_level_ff <= RST_REF_LEVEL;
        end else if (hclk_en && wr_pend_ff && wr_idx_ff == IDX_REF_LEVEL) begin
            ref_divider_level_ff <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable_ff <= RST_IRQ_CTRL[B_IRQ_EN];
        end else if (hclk_en && wr_pend_ff && wr_idx_ff == IDX_IRQ_CTRL) begin
            irq_enable_ff <= hwdata[B_IRQ_EN];
        end
    end

    // --- sleep gating and comparator power --------------------------------
    // idle sleep changes nothing; standby needs standby_run; power-down
    // always wins
    assign core_on = main_control_ff[B_ENABLE] & ~sleep_powerdown &
                     ~(sleep_standby & ~main_control_ff[B_STANDBY_RUN]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_on_ff <= 1'b0;
            pad_oe_ff <= 1'b0;
        end else if (hclk_en) begin
            cmp_on_ff <= core_on;
            pad_oe_ff <= core_on & main_control_ff[B_PAD_EN];
        end
    end

    // --- start-up wait ----------------------------------------------------
    // the divider reference settles slower, so it gets an extra wait
    assign wait_limit = (input_select_control_ff[B_MINUS_LO+1:B_MINUS_LO]
                         == MINUS_REF_DIV) ?
                        CNT_W'(STARTUP_CYC + REF_EXTRA_CYC) :
                        CNT_W'(STARTUP_CYC);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt_ff <= '0;
            valid_ff <= 1'b0;
        end else if (hclk_en) begin
            if (!cmp_on_ff) begin
                wait_cnt_ff <= '0;
                valid_ff <= 1'b0;
            end else if (!valid_ff) begin
                wait_cnt_ff <= wait_cnt_ff + CNT_W'(1);
                valid_ff <= (wait_cnt_ff == wait_limit - CNT_W'(1));
            end
        end
    end

    // --- output level path ------------------------------------------------
    // the core drives cmp_raw high when plus exceeds minus; inversion is
    // applied once here so every consumer sees the same polarity
    assign inv_level = cmp_raw ^ input_select_control_ff[B_INVERT];

    // pad and event stay combinational so they keep working while the
    // clock is stopped in standby
    assign pad_out = inv_level & pad_oe_ff;
    assign event_out = inv_level & cmp_on_ff;

    assign dif.ce = hclk_en;
    assign dif.valid = valid_ff;
    assign dif.edge_sel = main_control_ff[B_EDGE_LO+1:B_EDGE_LO];

    acc_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(inv_level),
        .dif(dif)
    );

    acc_edge u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .dif(dif)
    );

    // third stage after the synchroniser gives the three-cycle lag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= 1'b0;
        end else if (hclk_en) begin
            state_ff <= dif.level & valid_ff;
        end
    end

    // --- interrupt flag ---------------------------------------------------
    // an edge in the clearing cycle wins over the clear
    assign wr_status = wr_pend_ff && (wr_idx_ff == IDX_STATUS);

    always_comb begin
        nxt_flag = flag_ff;
        if (dif.hit) begin
            nxt_flag = 1'b1;
        end else if (wr_status && hwdata[B_FLAG]) begin
            nxt_flag = 1'b0;
        end
    end

    // a stopped clock holds the flag and state as they are
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (hclk_en) begin
            flag_ff <= nxt_flag;
            irq_ff <= nxt_flag & irq_enable_ff;
        end
    end

    // --- outputs ----------------------------------------------------------
    // this block has no event input port at all
    assign cmp_enable = cmp_on_ff;
    assign hysteresis_select = main_control_ff[B_HYS_LO+1:B_HYS_LO];
    assign low_power_select = main_control_ff[B_LOW_POWER];
    assign plus_input_select =
        input_select_control_ff[B_PLUS_LO+1:B_PLUS_LO];
    assign minus_input_select =
        input_select_control_ff[B_MINUS_LO+1:B_MINUS_LO];
    assign ref_divider_level = ref_divider_level_ff;
    assign pad_oe = pad_oe_ff;
    assign irq = irq_ff;
    assign hrdata = hrdata_ff;
    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule : acc_top
`default_nettype wire

// ---- tb/acc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// behavioural analog core: compares the selected plus and minus levels
module acc_core_model
    import acc_pkg::*;
(
    input wire logic hclk,
    input wire logic cmp_enable,
    input wire logic [1:0] plus_input_select,
    input wire logic [1:0] minus_input_select,
    input wire logic [7:0] ref_divider_level,
    input wire logic [55:0] vin,
    output logic cmp_raw
);
    int unsigned warm = 0;
    logic junk = 1'b0;
    logic [7:0] vp;
    logic [7:0] vm;
    // plus pins in bytes 0..3, minus pins in bytes 4..6
    assign vp = vin[8*plus_input_select +: 8];
    assign vm = (minus_input_select == MINUS_REF_DIV) ? ref_divider_level
        : vin[32 + 8*minus_input_select +: 8];
    // garbage while off or settling, so the design must mask it
    always @(posedge hclk) begin
        junk <= ~junk;
        warm <= cmp_enable ? warm + 1 : 0;
    end
    // settled output: high when plus is above minus
    assign cmp_raw = (cmp_enable && warm > STARTUP_CYC / 2) ? (vp > vm)
        : junk;
endmodule : acc_core_model
`default_nettype wire

// ---- tb/acc_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the comparator control block
module acc_top_monitor
    import acc_pkg::*;
#(
    parameter int REF_EXTRA_CYC = 100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hclk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic sleep_standby,
    input wire logic sleep_powerdown,
    input wire logic cmp_enable,
    input wire logic [1:0] hysteresis_select,
    input wire logic low_power_select,
    input wire logic [1:0] plus_input_select,
    input wire logic [1:0] minus_input_select,
    input wire logic [7:0] ref_divider_level,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic event_out,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // write address phase taken for one register
    sequence s_wr(logic [2:0] idx);
        hsel && htrans[1] && hwrite && hready && hclk_en
            && haddr == {27'h0, idx, 2'h0};
    endsequence
    // clock running and no sleep that stops the core
    sequence s_awake;
        hclk_en && !sleep_standby && !sleep_powerdown;
    endsequence
    property p_enable;
        s_wr(IDX_MAIN_CTRL) ##1 s_awake ##1 s_awake
            |=> cmp_enable == $past(hwdata[0], 2);
    endproperty
    a_enable: assert property (p_enable) else $error("enable bit");
    property p_main_fields;
        s_wr(IDX_MAIN_CTRL) ##1 hclk_en
            |=> {hysteresis_select, low_power_select} == $past(hwdata[3:1]);
    endproperty
    a_main_fields: assert property (p_main_fields)
        else $error("hysteresis or low power field");
    property p_input_fields;
        s_wr(IDX_INPUT_SEL) ##1 hclk_en |=> plus_input_select ==
            $past(hwdata[4:3]) && minus_input_select == $past(hwdata[1:0]);
    endproperty
    a_input_fields: assert property (p_input_fields)
        else $error("input select fields");
    property p_ref;
        s_wr(IDX_REF_LEVEL) ##1 hclk_en
            |=> ref_divider_level == $past(hwdata[7:0]);
    endproperty
    a_ref: assert property (p_ref) else $error("divider level");
    property p_pdown;
        sleep_powerdown && hclk_en |=> !cmp_enable && !pad_oe;
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down");
    property p_pad_off;
        !pad_oe |-> !pad_out;
    endproperty
    a_pad_off: assert property (p_pad_off) else $error("pad driven");
    property p_pad_evt;
        pad_oe |-> pad_out == event_out;
    endproperty
    a_pad_evt: assert property (p_pad_evt) else $error("pad vs event");
    property p_evt_off;
        !cmp_enable |-> !event_out;
    endproperty
    a_evt_off: assert property (p_evt_off) else $error("event on");
    property p_freeze;
        !hclk_en |=> $stable(irq) && $stable(pad_oe) && $stable(hrdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen state");
    property p_rd_idle;
        hclk_en && !(hsel && htrans[1] && !hwrite && hready)
            |=> hrdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
endmodule : acc_top_monitor
bind acc_top acc_top_monitor #(.REF_EXTRA_CYC(REF_EXTRA_CYC)) u_acc_top_monitor (
    .hclk(hclk), .hresetn(hresetn), .hclk_en(hclk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .sleep_standby(sleep_standby),
    .sleep_powerdown(sleep_powerdown), .cmp_enable(cmp_enable),
    .hysteresis_select(hysteresis_select),
    .low_power_select(low_power_select),
    .plus_input_select(plus_input_select),
    .minus_input_select(minus_input_select),
    .ref_divider_level(ref_divider_level), .pad_out(pad_out),
    .pad_oe(pad_oe), .event_out(event_out), .irq(irq));
`default_nettype wire

// ---- tb/acc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb
    import acc_pkg::*;
;
    logic hclk = 0, hresetn = 0, hclk_en = 1, hsel = 1, hwrite = 0;
    logic hready = 1, sleep_idle = 0, sleep_standby = 0, sleep_powerdown = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0, hysteresis_select, plus_input_select;
    logic [1:0] minus_input_select;
    logic [2:0] hsize = 3'h2;
    logic [7:0] ref_divider_level;
    // plus pin 0 starts above minus pin 0, so the core settles high
    logic [55:0] vin = 56'h00_0080_0000_00c0;
    logic hreadyout, hresp, cmp_raw, cmp_enable, low_power_select;
    logic pad_out, pad_oe, event_out, irq;
    int miscompares = 0, n_compared = 0, cycles = 0;
    acc_top #(.REF_EXTRA_CYC(20)) u_acc_top (.hclk(hclk), .hresetn(hresetn),
        .hclk_en(hclk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sleep_idle(sleep_idle), .sleep_standby(sleep_standby),
        .sleep_powerdown(sleep_powerdown), .cmp_raw(cmp_raw),
        .cmp_enable(cmp_enable), .hysteresis_select(hysteresis_select),
        .low_power_select(low_power_select),
        .plus_input_select(plus_input_select),
        .minus_input_select(minus_input_select),
        .ref_divider_level(ref_divider_level), .pad_out(pad_out),
        .pad_oe(pad_oe), .event_out(event_out), .irq(irq));
    acc_core_model u_acc_core_model (.hclk(hclk), .cmp_enable(cmp_enable),
        .plus_input_select(plus_input_select),
        .minus_input_select(minus_input_select),
        .ref_divider_level(ref_divider_level), .vin(vin), .cmp_raw(cmp_raw));
    always #2.5 hclk = ~hclk;
    // hang guard, about four times the roughly 1200 cycles the run needs
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // single word write; entered right after a rising edge
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        haddr <= {27'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wr
    // single word read, data taken at the falling edge inside the data phase
    task automatic rd(input logic [2:0] idx, input logic [7:0] e);
        logic [31:0] v;
        logic r;
        haddr <= {27'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do begin
            @(negedge hclk);
            v = hrdata;
            r = hreadyout;
            @(posedge hclk);
        end while (r !== 1'b1);
        chk(v, {24'h0, e});
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle
    initial begin
        idle(5);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, unmapped slots read zero
        for (int i = 0; i < 8; i++)
            rd(i[2:0], (i == 4) ? RST_REF_LEVEL : 8'h00);
        wr(IDX_INPUT_SEL, 8'hff);
        rd(IDX_INPUT_SEL, 8'h9b);
        wr(IDX_IRQ_CTRL, 8'hff);
        rd(IDX_IRQ_CTRL, 8'h01);
        wr(IDX_REF_LEVEL, 8'h5a);
        rd(IDX_REF_LEVEL, 8'h5a);
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00);
        wr(IDX_MAIN_CTRL, 8'hfe);
        rd(IDX_MAIN_CTRL, 8'hfe);
        wr(IDX_INPUT_SEL, 8'h00);
        // power up with plus above minus; no flag at start-up end
        wr(IDX_MAIN_CTRL, 8'h41);
        idle(STARTUP_CYC + 8);
        rd(IDX_STATUS, 8'h10);
        chk({pad_out, event_out}, 32'h3);
        chk({hreadyout, hresp}, 32'h2);
        // every edge code, the reserved one included
        for (int m = 0; m < 4; m++) begin
            wr(IDX_MAIN_CTRL, {2'b01, m[1:0], 4'h1});
            wr(IDX_STATUS, 8'h01);
            vin[7:0] <= 8'h40;
            idle(6);
            rd(IDX_STATUS, {7'h0, m == 0 || m == 2});
            chk({31'h0, irq}, {31'h0, m == 0 || m == 2});
            wr(IDX_STATUS, 8'h01);
            vin[7:0] <= 8'hc0;
            idle(6);
            rd(IDX_STATUS, {4'h1, 3'h0, m == 0 || m == 3});
        end
        // inversion turns the high level into a falling edge
        wr(IDX_STATUS, 8'h01);
        wr(IDX_INPUT_SEL, 8'h80);
        idle(6);
        rd(IDX_STATUS, 8'h00);
        chk({pad_out, event_out}, 32'h0);
        wr(IDX_INPUT_SEL, 8'h03);
        // let the select register settle before looking at the event
        idle(1);
        chk({31'h0, event_out}, 32'h1);
        vin[7:0] <= 8'h50;
        idle(2);
        chk({31'h0, event_out}, 32'h0);
        vin[15:8] <= 8'hff;
        wr(IDX_INPUT_SEL, 8'h0b);
        idle(1);
        chk({31'h0, event_out}, 32'h1);
        sleep_idle <= 1'b1;
        idle(3);
        chk({pad_oe, cmp_enable}, 32'h3);
        sleep_idle <= 1'b0;
        sleep_powerdown <= 1'b1;
        idle(3);
        chk({pad_oe, cmp_enable}, 32'h0);
        sleep_powerdown <= 1'b0;
        sleep_standby <= 1'b1;
        idle(3);
        chk({pad_oe, cmp_enable}, 32'h0);
        wr(IDX_STATUS, 8'h01);
        wr(IDX_MAIN_CTRL, 8'hc1);
        // the core restarts, so wait out its start-up before stopping
        idle(STARTUP_CYC + 8);
        chk({pad_oe, cmp_enable, irq}, 32'h6);
        // clock stopped: pad and event still follow, status frozen
        hclk_en <= 1'b0;
        vin[15:8] <= 8'h00;
        idle(8);
        chk({pad_out, event_out, irq}, 32'h0);
        vin[15:8] <= 8'hff;
        idle(1);
        chk({pad_out, event_out, irq}, 32'h6);
        hclk_en <= 1'b1;
        sleep_standby <= 1'b0;
        idle(4);
        complete_run();
    end
endmodule : acc_top_tb
`default_nettype wire
